// file: src/ulmcs_pkg.sv
// Package: constants for the line and modem control and status block.
// Assumes an 8-bit register port with a 3-bit offset and one 200 MHz clock.
package ulmcs_pkg;

   // ------------------------------------------------------------
   // Register offsets
   // ------------------------------------------------------------
   localparam logic [2:0] OFS_DATA = 3'h0;
   localparam logic [2:0] OFS_IRQ_ENABLE = 3'h1;
   localparam logic [2:0] OFS_LINE_CONTROL = 3'h3;
   localparam logic [2:0] OFS_MODEM_CONTROL = 3'h4;
   localparam logic [2:0] OFS_LINE_STATUS = 3'h5;
   localparam logic [2:0] OFS_MODEM_STATUS = 3'h6;

   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int LC_PARITY_EN = 3;
   localparam int LC_EVEN_SEL = 4;
   localparam int LC_STICK = 5;
   localparam int LC_BREAK = 6;
   localparam int LC_DIV_ACCESS = 7;
   localparam int MC_TERM_READY = 0;
   localparam int MC_SEND_REQ = 1;
   localparam int MC_USER_USER_OUTPUT_ONE = 2;
   localparam int MC_IRQ_GATE = 3;
   localparam int MC_LOOPBACK = 4;
   localparam int IE_RX_DATA = 0;
   localparam int IE_TX_EMPTY = 1;
   localparam int IE_LINE_ERR = 2;
   localparam int IE_MODEM = 3;

   // ------------------------------------------------------------
   // Reset values and bit timing
   // ------------------------------------------------------------
   localparam logic [7:0] LINE_CONTROL_RST = 8'h00;
   localparam logic [4:0] MODEM_CONTROL_RST = 5'h00;
   localparam logic [3:0] IRQ_ENABLE_RST = 4'h0;
   localparam logic [15:0] DIVISOR_RST = 16'h0001;
   localparam logic [4:0] PIN_SYNC_RST = 5'h1f;
   localparam logic [3:0] OVS_LAST = 4'hf;
   localparam logic [3:0] OVS_MID = 4'h7;
   localparam logic [2:0] DATA_LAST = 3'h7;

   // ------------------------------------------------------------
   // State types
   // ------------------------------------------------------------
   typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP} ulmcs_tx_state_t;
   typedef enum logic [2:0] {
      RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP, RX_BREAK
   } ulmcs_rx_state_t;

endpackage : ulmcs_pkg

// file: src/ulmcs_sync.sv
// Three-stage pin synchroniser with agreement filter.
// Assumes asynchronous pin levels; output changes once stages two and three agree.
`timescale 1ns/1ps
module ulmcs_sync #(
   parameter int W = 5,
   parameter logic [W-1:0] RST = '1
) (
   input wire logic clock,
   input wire logic arst_n,
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);
   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;
   logic [W-1:0] s3_q;
   logic [W-1:0] out_q;

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         s1_q <= RST;
         s2_q <= RST;
         s3_q <= RST;
         out_q <= RST;
      end else begin
         s1_q <= din;
         s2_q <= s1_q;
         s3_q <= s2_q;
         for (int i = 0; i < W; i++) begin
            if (s2_q[i] == s3_q[i]) begin
               out_q[i] <= s3_q[i];
            end
         end
      end
   end

   assign dout = out_q;
endmodule : ulmcs_sync

// file: src/ulmcs_parity.sv
// Parity bit for one eight-bit character.
// Assumes the caller applies it only while parity is enabled.
`timescale 1ns/1ps
module ulmcs_parity (
   input wire logic [7:0] data,
   input wire logic even_sel,
   input wire logic stick,
   output logic par
);
   // Stick forces the inverse of even select
   assign par = stick ? ~even_sel : (even_sel ? ^data : ~^data);
endmodule : ulmcs_parity

// file: src/ulmcs_top.sv
// Serial port line and modem control and status, with its bit engines.
// Assumes a one-cycle register port and asynchronous serial and modem pins.
//
// Function
// - With parity enabled, a parity bit follows data on transmit and is checked.
// - Parity is odd when even select is 0, even when it is 1.
// - Stick parity sends and expects the inverse of even select.
// - Break control holds the serial output low until cleared.
// - Divisor access selects divisor latches or data and enable registers.
// - Ready and send request outputs go low when their control bits are 1, except in loopback.
// - User output one is a plain read/write bit with no pin.
// - Interrupt gate 0 floats the interrupt output; 1 enables it.
// - Loopback marks the output unless break is set, loops transmit to receive, parks modem outputs high.
// - Loopback routes the four modem controls to the four modem inputs.
// - In loopback, interrupts still work, modem ones sourced from control bits.
// - Top three modem control bits read zero.
// - Receive ready sets on a received character, clears when it is read.
// - Overrun sets when an unread character is overwritten; status read clears.
// - Parity error flags a bad parity character; status read clears.
// - Framing error on low stop bit; resynchronise treating it as start.
// - Break flags a long low line, stores zero, waits half bit high.
// - Overrun, parity, framing or break raise the line status interrupt.
// - Holding empty sets on transfer to shifter, clears on host write.
// - Transmitter empty is 1 only with holding and shift registers empty.
// - Top line status bit reads zero without FIFO mode.
// - Send and ready changes and ring trailing edge set flags; status read clears.
// - Carrier change is flagged; any change flag raises the modem interrupt.
// - Upper modem status bits show inverted inputs, or control bits in loopback.
//
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
module ulmcs_top (
   input wire logic clock,
   input wire logic arst_n,
   input wire logic [2:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr_en,
   input wire logic rd_en,
   output logic [7:0] rdata,
   output logic txd,
   input wire logic rxd,
   input wire logic clear_to_send_n,
   input wire logic set_ready_n,
   input wire logic ring_indicator_n,
   input wire logic carrier_detect_n,
   output logic terminal_ready_n,
   output logic send_request_n,
   output logic irq_out,
   output logic irq_oe_n
);
   import ulmcs_pkg::*;

   // ------------------------------------------------------------
   // Register decode
   // ------------------------------------------------------------
   logic [7:0] line_control_q;
   logic [4:0] modem_control_q;
   logic [3:0] ier_q;
   logic [15:0] divisor_q;
   logic divisor_access_select;
   logic wr_thr, rd_rbr, rd_ls, rd_ms, wr_div;
   logic loop_en;

   assign divisor_access_select = line_control_q[LC_DIV_ACCESS];
   assign loop_en = modem_control_q[MC_LOOPBACK];
   assign wr_thr = wr_en && addr == OFS_DATA && !divisor_access_select;
   assign rd_rbr = rd_en && addr == OFS_DATA && !divisor_access_select;
   assign wr_div = wr_en && divisor_access_select && (addr == OFS_DATA || addr == OFS_IRQ_ENABLE);
   assign rd_ls = rd_en && addr == OFS_LINE_STATUS;
   assign rd_ms = rd_en && addr == OFS_MODEM_STATUS;

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         line_control_q <= LINE_CONTROL_RST;
         modem_control_q <= MODEM_CONTROL_RST;
         ier_q <= IRQ_ENABLE_RST;
         divisor_q <= DIVISOR_RST;
      end else if (wr_en) begin
         case (addr)
            OFS_DATA: begin
               if (divisor_access_select) divisor_q[7:0] <= wdata;
            end
            OFS_IRQ_ENABLE: begin
               if (divisor_access_select) divisor_q[15:8] <= wdata;
               else ier_q <= wdata[3:0];
            end
            OFS_LINE_CONTROL: line_control_q <= wdata;
            OFS_MODEM_CONTROL: modem_control_q <= wdata[4:0];
            default: ;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Baud tick at sixteen times the bit rate
   // ------------------------------------------------------------
   logic [15:0] baud_cnt_q;
   logic tick;
   assign tick = baud_cnt_q == 16'h0000;

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) baud_cnt_q <= 16'h0000;
      else if (wr_div || tick) baud_cnt_q <= (divisor_q > 16'h0001) ? divisor_q - 16'h0001 : 16'h0000;
      else baud_cnt_q <= baud_cnt_q - 16'h0001;
   end

   // ------------------------------------------------------------
   // Pin synchronisers and modem inputs
   // ------------------------------------------------------------
   logic [4:0] pins_s;
   logic [3:0] modem_in;
   logic [3:0] modem_prev_q;
   logic [3:0] delta_q;
   logic [3:0] delta_set;

   ulmcs_sync #(.W(5), .RST(PIN_SYNC_RST)) u_sync (
      .clock(clock),
      .arst_n(arst_n),
      .din({rxd, carrier_detect_n, ring_indicator_n, set_ready_n, clear_to_send_n}),
      .dout(pins_s)
   );

   // Order: carrier, ring, ready, send, all active high
   assign modem_in = loop_en ? {modem_control_q[MC_IRQ_GATE], modem_control_q[MC_USER_USER_OUTPUT_ONE],
                                modem_control_q[MC_TERM_READY], modem_control_q[MC_SEND_REQ]}
                             : ~pins_s[3:0];
   assign delta_set = {modem_in[3] ^ modem_prev_q[3], modem_prev_q[2] & ~modem_in[2],
                       modem_in[1:0] ^ modem_prev_q[1:0]};

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) modem_prev_q <= 4'h0;
      else modem_prev_q <= modem_in;
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) delta_q <= 4'h0;
      else delta_q <= (rd_ms ? 4'h0 : delta_q) | delta_set;
   end

   assign terminal_ready_n = loop_en | ~modem_control_q[MC_TERM_READY];
   assign send_request_n = loop_en | ~modem_control_q[MC_SEND_REQ];

   // ------------------------------------------------------------
   // Transmitter
   // ------------------------------------------------------------
   ulmcs_tx_state_t tx_state_q;
   logic [7:0] thr_q, tsr_q;
   logic thr_full_q, tx_par_q, tx_par, tx_line, txd_q;
   logic [3:0] tx_cnt_q;
   logic [2:0] tx_bit_q;
   logic thr_load, tx_bit_end, holding_empty_flag, transmitter_empty_flag;

   ulmcs_parity u_tx_par (
      .data(thr_q),
      .even_sel(line_control_q[LC_EVEN_SEL]),
      .stick(line_control_q[LC_STICK]),
      .par(tx_par)
   );

   assign thr_load = tx_state_q == TX_IDLE && thr_full_q && tick;
   assign tx_bit_end = tick && tx_cnt_q == OVS_LAST;
   assign holding_empty_flag = !thr_full_q;
   assign transmitter_empty_flag = !thr_full_q && tx_state_q == TX_IDLE;

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         thr_q <= 8'h00;
         thr_full_q <= 1'b0;
      end else begin
         if (wr_thr) thr_q <= wdata;
         if (wr_thr) thr_full_q <= 1'b1;
         else if (thr_load) thr_full_q <= 1'b0;
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         tx_state_q <= TX_IDLE;
         tsr_q <= 8'h00;
         tx_par_q <= 1'b0;
         tx_cnt_q <= 4'h0;
         tx_bit_q <= 3'h0;
      end else begin
         if (tick && tx_state_q != TX_IDLE) tx_cnt_q <= tx_cnt_q + 4'h1;
         case (tx_state_q)
            TX_IDLE: begin
               tx_cnt_q <= 4'h0;
               if (thr_load) begin
                  tsr_q <= thr_q;
                  tx_par_q <= tx_par;
                  tx_state_q <= TX_START;
               end
            end
            TX_START: begin
               if (tx_bit_end) begin
                  tx_bit_q <= 3'h0;
                  tx_state_q <= TX_DATA;
               end
            end
            TX_DATA: begin
               if (tx_bit_end) begin
                  tsr_q <= {1'b0, tsr_q[7:1]};
                  tx_bit_q <= tx_bit_q + 3'h1;
                  if (tx_bit_q == DATA_LAST) begin
                     tx_state_q <= line_control_q[LC_PARITY_EN] ? TX_PARITY : TX_STOP;
                  end
               end
            end
            TX_PARITY: if (tx_bit_end) tx_state_q <= TX_STOP;
            TX_STOP: if (tx_bit_end) tx_state_q <= TX_IDLE;
            default: tx_state_q <= TX_IDLE;
         endcase
      end
   end

   always_comb begin
      case (tx_state_q)
         TX_START: tx_line = 1'b0;
         TX_DATA: tx_line = tsr_q[0];
         TX_PARITY: tx_line = tx_par_q;
         default: tx_line = 1'b1;
      endcase
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) txd_q <= 1'b1;
      else if (line_control_q[LC_BREAK]) txd_q <= 1'b0;
      else if (loop_en) txd_q <= 1'b1;
      else txd_q <= tx_line;
   end
   assign txd = txd_q;

   // ------------------------------------------------------------
   // Receiver
   // ------------------------------------------------------------
   ulmcs_rx_state_t rx_state_q;
   logic rx_in, rx_par_q, rx_exp_par;
   logic [7:0] rx_shift_q, rbr_q;
   logic [3:0] rx_cnt_q;
   logic [2:0] rx_bit_q;
   logic rx_sample, char_done, brk_ev, fe_ev, pe_ev, oe_ev;
   logic dr_q, oe_q, pe_q, fe_q, bi_q;

   assign rx_in = loop_en ? tx_line : pins_s[4];
   assign rx_sample = tick && rx_cnt_q == OVS_LAST;
   assign char_done = rx_state_q == RX_STOP && rx_sample;

   ulmcs_parity u_rx_par (
      .data(rx_shift_q),
      .even_sel(line_control_q[LC_EVEN_SEL]),
      .stick(line_control_q[LC_STICK]),
      .par(rx_exp_par)
   );

   assign brk_ev = char_done && !rx_in && rx_shift_q == 8'h00 &&
                   !(line_control_q[LC_PARITY_EN] && rx_par_q);
   assign fe_ev = char_done && !rx_in && !brk_ev;
   assign pe_ev = char_done && !brk_ev && line_control_q[LC_PARITY_EN] &&
                  rx_par_q != rx_exp_par;
   assign oe_ev = char_done && dr_q && !rd_rbr;

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         rx_state_q <= RX_IDLE;
         rx_cnt_q <= 4'h0;
         rx_bit_q <= 3'h0;
         rx_shift_q <= 8'h00;
         rx_par_q <= 1'b0;
      end else begin
         if (tick) rx_cnt_q <= rx_cnt_q + 4'h1;
         case (rx_state_q)
            RX_IDLE: begin
               rx_cnt_q <= 4'h0;
               if (!rx_in) rx_state_q <= RX_START;
            end
            RX_START: begin
               if (tick && rx_cnt_q == OVS_MID) begin
                  rx_cnt_q <= 4'h0;
                  rx_bit_q <= 3'h0;
                  rx_state_q <= rx_in ? RX_IDLE : RX_DATA;
               end
            end
            RX_DATA: begin
               if (rx_sample) begin
                  rx_shift_q <= {rx_in, rx_shift_q[7:1]};
                  rx_bit_q <= rx_bit_q + 3'h1;
                  if (rx_bit_q == DATA_LAST) begin
                     rx_state_q <= line_control_q[LC_PARITY_EN] ? RX_PARITY : RX_STOP;
                  end
               end
            end
            RX_PARITY: begin
               if (rx_sample) begin
                  rx_par_q <= rx_in;
                  rx_state_q <= RX_STOP;
               end
            end
            RX_STOP: begin
               if (rx_sample) begin
                  rx_bit_q <= 3'h0;
                  if (rx_in) rx_state_q <= RX_IDLE;
                  else if (brk_ev) rx_state_q <= RX_BREAK;
                  else rx_state_q <= RX_DATA;
               end
            end
            RX_BREAK: begin
               // Needs half a bit of high line before restart
               if (rx_in == 1'b0) rx_cnt_q <= 4'h0;
               else if (tick && rx_cnt_q == OVS_MID) rx_state_q <= RX_IDLE;
            end
            default: rx_state_q <= RX_IDLE;
         endcase
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         rbr_q <= 8'h00;
         dr_q <= 1'b0;
      end else begin
         if (char_done) rbr_q <= brk_ev ? 8'h00 : rx_shift_q;
         dr_q <= (rd_rbr ? 1'b0 : dr_q) | char_done;
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         oe_q <= 1'b0;
         pe_q <= 1'b0;
         fe_q <= 1'b0;
         bi_q <= 1'b0;
      end else begin
         oe_q <= (rd_ls ? 1'b0 : oe_q) | oe_ev;
         pe_q <= (rd_ls ? 1'b0 : pe_q) | pe_ev;
         fe_q <= (rd_ls ? 1'b0 : fe_q) | fe_ev;
         bi_q <= (rd_ls ? 1'b0 : bi_q) | brk_ev;
      end
   end

   // ------------------------------------------------------------
   // Read data and interrupt
   // ------------------------------------------------------------
   logic [7:0] rdata_q;
   logic irq_q;

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) rdata_q <= 8'h00;
      else if (!rd_en) rdata_q <= 8'h00;
      else begin
         case (addr)
            OFS_DATA: rdata_q <= divisor_access_select ? divisor_q[7:0] : rbr_q;
            OFS_IRQ_ENABLE: rdata_q <= divisor_access_select ? divisor_q[15:8] : {4'h0, ier_q};
            OFS_LINE_CONTROL: rdata_q <= line_control_q;
            OFS_MODEM_CONTROL: rdata_q <= {3'h0, modem_control_q};
            OFS_LINE_STATUS: rdata_q <= {1'b0, transmitter_empty_flag, holding_empty_flag, bi_q, fe_q, pe_q, oe_q, dr_q};
            OFS_MODEM_STATUS: rdata_q <= {modem_in, delta_q};
            default: rdata_q <= 8'h00;
         endcase
      end
   end
   assign rdata = rdata_q;

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) irq_q <= 1'b0;
      else irq_q <= (ier_q[IE_LINE_ERR] && (oe_q || pe_q || fe_q || bi_q)) ||
                    (ier_q[IE_RX_DATA] && dr_q) || (ier_q[IE_TX_EMPTY] && holding_empty_flag) ||
                    (ier_q[IE_MODEM] && delta_q != 4'h0);
   end
   assign irq_out = irq_q;
   assign irq_oe_n = ~modem_control_q[MC_IRQ_GATE];

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (!arst_n);

   sequence s_last_data_bit;
      tx_state_q == TX_DATA && tx_bit_q == DATA_LAST && tx_bit_end;
   endsequence
   sequence s_mc_write(int b);
      wr_en && addr == OFS_MODEM_CONTROL && wdata[b] && !wdata[MC_LOOPBACK];
   endsequence

   chk_parity_slot_entry: assert property (
      s_last_data_bit ##0 line_control_q[LC_PARITY_EN] |=> tx_state_q == TX_PARITY)
      else $error("parity slot not entered");
   chk_break_holds_low: assert property (
      line_control_q[LC_BREAK] [*2] |-> !txd) else $error("break not holding txd low");
   chk_loop_marks_txd: assert property (
      !line_control_q[LC_BREAK] && loop_en |=> txd) else $error("loopback txd not marking");
   chk_ready_pin_drive: assert property (
      s_mc_write(MC_TERM_READY) |=> !terminal_ready_n) else $error("ready pin not low");
   chk_irq_gate_float: assert property (
      wr_en && addr == OFS_MODEM_CONTROL && !wdata[MC_IRQ_GATE] |=> irq_oe_n)
      else $error("interrupt not floated");
   chk_mc_upper_zero: assert property (
      rd_en && addr == OFS_MODEM_CONTROL |=> rdata[7:5] == 3'h0) else $error("mc upper bits set");
   chk_ls_top_zero: assert property (
      rd_ls |=> rdata[7] == 1'b0) else $error("line status top bit set");
   chk_ready_on_char: assert property (
      char_done |=> dr_q) else $error("receive ready not set");
   chk_overrun_set: assert property (
      char_done && dr_q && !rd_rbr |=> oe_q) else $error("overrun not flagged");
   chk_status_read_clears: assert property (
      rd_ls && !char_done |=> !pe_q && !fe_q && !bi_q && !oe_q) else $error("errors not cleared");
   chk_holding_empty_clear: assert property (
      wr_thr |=> !holding_empty_flag && !transmitter_empty_flag) else $error("empty flags not cleared on write");
   chk_msr_loop_source: assert property (
      rd_ms && loop_en |=> rdata[5] == $past(modem_control_q[MC_TERM_READY]))
      else $error("loopback status bit wrong");
   chk_delta_read_clear: assert property (
      rd_ms && delta_set == 4'h0 |=> delta_q == 4'h0) else $error("change flags not cleared");
   chk_modem_irq_raise: assert property (
      ier_q[IE_MODEM] && delta_q != 4'h0 |=> irq_out) else $error("modem interrupt missing");

endmodule : ulmcs_top

// file: testbench/ulmcs_term.sv
// Partner: terminal on the serial line, drives receive line and modem pins.
// Assumes divisor 1, so one bit lasts 16 clocks.
`timescale 1ns/1ps
module ulmcs_term (
   input wire logic clock,
   output logic rxd,
   output logic [3:0] modem_n
);
   initial begin
      rxd = 1'b1;
      modem_n = 4'hf;
   end
   // Frame bits sent LSB first, then the line marks idle
   task automatic send(input logic [11:0] f, input int n);
      for (int i = 0; i < n; i++) begin
         rxd <= f[i];
         repeat (16) @(posedge clock);
      end
      rxd <= 1'b1;
   endtask : send
endmodule : ulmcs_term

// file: testbench/tb_ulmcs_top.sv
// Testbench: register port, serial line and modem pin scenarios.
// Assumes 200 MHz clock and divisor 1, one bit is 16 clocks.
`timescale 1ns/1ps
module tb_ulmcs_top;
   import ulmcs_pkg::*;
   logic clock, arst_n, wr_en, rd_en, txd, rxd, terminal_ready_n, send_request_n;
   logic irq_out, irq_oe_n;
   logic [2:0] addr;
   logic [7:0] wdata, rdata;
   logic [3:0] mn;
   int mismatches = 0;
   int comparisons = 0;
   ulmcs_top u_ulmcs_top (.clock(clock), .arst_n(arst_n), .addr(addr), .wdata(wdata),
      .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .txd(txd), .rxd(rxd),
      .clear_to_send_n(mn[0]), .set_ready_n(mn[1]), .ring_indicator_n(mn[2]),
      .carrier_detect_n(mn[3]), .terminal_ready_n(terminal_ready_n),
      .send_request_n(send_request_n), .irq_out(irq_out), .irq_oe_n(irq_oe_n));
   ulmcs_term u_ulmcs_term (.clock(clock), .rxd(rxd), .modem_n(mn));
   // ------------------------------------------------------------
   // Bus and compare tasks
   // ------------------------------------------------------------
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      addr <= a;
      wdata <= d;
      wr_en <= 1'b1;
      @(posedge clock);
      wr_en <= 1'b0;
      @(posedge clock);
   endtask : wr
   task automatic rd(input logic [2:0] a, output logic [7:0] v);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clock);
      rd_en <= 1'b0;
      #1 v = rdata;
      @(posedge clock);
   endtask : rd
   task automatic rdc(input logic [2:0] a, input logic [7:0] e);
      logic [7:0] v;
      rd(a, v);
      chk(v, e);
   endtask : rdc
   task automatic clk(input int n);
      repeat (n) @(posedge clock);
   endtask : clk
   task automatic mset(input logic [3:0] m);
      u_ulmcs_term.modem_n <= m;
      clk(8);
   endtask : mset
   task automatic low_count(output int n);
      n = 0;
      repeat (200) begin
         @(posedge clock);
         n += int'(!txd);
      end
   endtask : low_count
   task automatic grab(output logic [10:0] f);
      int n;
      n = 0;
      while (txd !== 1'b0 && n < 400) begin
         @(posedge clock);
         n++;
      end
      clk(8);
      for (int i = 0; i < 11; i++) begin
         f[i] = txd;
         clk(16);
      end
   endtask : grab
   function automatic logic [11:0] frm(input logic [7:0] d, input logic bad);
      return {2'b11, ^d ^ bad, d, 1'b0};
   endfunction : frm
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_regs();
      rdc(OFS_LINE_STATUS, 8'h60);
      rdc(3'h2, 8'h00);
      chk(irq_oe_n, 1'b1);
      wr(OFS_MODEM_CONTROL, 8'hef);
      rdc(OFS_MODEM_CONTROL, 8'h0f);
      chk({terminal_ready_n, send_request_n, irq_oe_n}, 3'h0);
      wr(OFS_MODEM_CONTROL, 8'h04);
      rdc(OFS_MODEM_CONTROL, 8'h04);
      chk({terminal_ready_n, send_request_n, irq_oe_n}, 3'h7);
      wr(OFS_IRQ_ENABLE, 8'h05);
      wr(OFS_LINE_CONTROL, 8'h80);
      wr(OFS_DATA, 8'h02);
      rdc(OFS_DATA, 8'h02);
      rdc(OFS_IRQ_ENABLE, 8'h00);
      wr(OFS_DATA, 8'h01);
      wr(OFS_LINE_CONTROL, 8'h00);
      rdc(OFS_IRQ_ENABLE, 8'h05);
      rdc(OFS_LINE_STATUS, 8'h60);
      $display("t_regs done");
   endtask : t_regs
   task automatic t_tx();
      logic [10:0] f;
      logic p;
      int n;
      for (int m = 0; m < 4; m++) begin
         wr(OFS_LINE_CONTROL, {2'h0, m[1:0], 4'h8});
         wr(OFS_DATA, 8'h35);
         rdc(OFS_LINE_STATUS, 8'h20);
         grab(f);
         p = m[1] ? !m[0] : (m[0] ? ^8'h35 : ~^8'h35);
         chk(f, {1'b1, p, 8'h35, 1'b0});
      end
      rdc(OFS_LINE_STATUS, 8'h60);
      wr(OFS_LINE_CONTROL, 8'h40);
      wr(OFS_DATA, 8'hff);
      low_count(n);
      chk(n, 16'd200);
      wr(OFS_LINE_CONTROL, 8'h00);
      clk(1);
      chk(txd, 1'b1);
      $display("t_tx done");
   endtask : t_tx
   task automatic t_rx();
      wr(OFS_LINE_CONTROL, 8'h18);
      wr(OFS_IRQ_ENABLE, 8'h04);
      wr(OFS_MODEM_CONTROL, 8'h08);
      u_ulmcs_term.send(frm(8'h5a, 1'b0), 11);
      rdc(OFS_LINE_STATUS, 8'h61);
      rdc(OFS_DATA, 8'h5a);
      rdc(OFS_LINE_STATUS, 8'h60);
      chk(irq_out, 1'b0);
      u_ulmcs_term.send(frm(8'h3c, 1'b1), 11);
      clk(4);
      chk(irq_out, 1'b1);
      rdc(OFS_LINE_STATUS, 8'h65);
      rdc(OFS_LINE_STATUS, 8'h61);
      clk(2);
      chk(irq_out, 1'b0);
      rdc(OFS_DATA, 8'h3c);
      u_ulmcs_term.send(frm(8'h11, 1'b0), 11);
      u_ulmcs_term.send(frm(8'h22, 1'b0), 11);
      rdc(OFS_LINE_STATUS, 8'h63);
      rdc(OFS_DATA, 8'h22);
      wr(OFS_LINE_CONTROL, 8'h00);
      u_ulmcs_term.send({3'h0, 8'h81, 1'b0}, 10);
      rdc(OFS_LINE_STATUS, 8'h69);
      rdc(OFS_DATA, 8'h81);
      clk(170);
      rdc(OFS_LINE_STATUS, 8'h61);
      rdc(OFS_DATA, 8'hff);
      u_ulmcs_term.send(12'h000, 12);
      rdc(OFS_LINE_STATUS, 8'h71);
      clk(20);
      rdc(OFS_DATA, 8'h00);
      rdc(OFS_LINE_STATUS, 8'h60);
      $display("t_rx done");
   endtask : t_rx
   task automatic t_modem();
      wr(OFS_IRQ_ENABLE, 8'h08);
      rdc(OFS_MODEM_STATUS, 8'h00);
      mset(4'he);
      chk(irq_out, 1'b1);
      rdc(OFS_MODEM_STATUS, 8'h11);
      rdc(OFS_MODEM_STATUS, 8'h10);
      clk(2);
      chk(irq_out, 1'b0);
      mset(4'hb);
      rdc(OFS_MODEM_STATUS, 8'h41);
      mset(4'hf);
      rdc(OFS_MODEM_STATUS, 8'h04);
      mset(4'h5);
      rdc(OFS_MODEM_STATUS, 8'haa);
      $display("t_modem done");
   endtask : t_modem
   task automatic t_loop();
      logic [7:0] v;
      int n;
      wr(OFS_MODEM_CONTROL, 8'h1f);
      chk({txd, terminal_ready_n, send_request_n}, 3'h7);
      clk(6);
      rd(OFS_MODEM_STATUS, v);
      rdc(OFS_MODEM_STATUS, 8'hf0);
      wr(OFS_MODEM_CONTROL, 8'h11);
      clk(6);
      rdc(OFS_MODEM_STATUS, 8'h2d);
      wr(OFS_DATA, 8'hc3);
      low_count(n);
      chk(n, 16'd0);
      rdc(OFS_LINE_STATUS, 8'h61);
      rdc(OFS_DATA, 8'hc3);
      $display("t_loop done");
   endtask : t_loop
   task automatic tally_and_finish();
      $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : tally_and_finish
   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end
   initial begin
      arst_n = 1'b0;
      addr = 3'h0;
      wdata = 8'h00;
      wr_en = 1'b0;
      rd_en = 1'b0;
      clk(16);
      arst_n <= 1'b1;
      clk(1);
      t_regs();
      t_tx();
      t_rx();
      t_modem();
      t_loop();
      tally_and_finish();
   end
   initial begin
      #200000;
      mismatches++;
      tally_and_finish();
   end
endmodule : tb_ulmcs_top
